// ### bridge_supervisor_pkg.sv
`default_nettype none

package bridge_supervisor_pkg;

	// register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] BRIDGE_ACTIVATION_CTRL = 8'h00;
	localparam logic [7:0] GLOBAL_STATUS_ONE = 8'h04;
	localparam logic [7:0] OVERCURRENT_STATUS_REG = 8'h08;
	localparam logic [7:0] OPEN_LOAD_STATUS_REG = 8'h0C;
	localparam int ADDR_W = 8;

	// global status bit positions
	localparam int THERMAL_PREWARN_BIT = 1;
	localparam int THERMAL_CUTOFF_BIT = 2;
	localparam int SUPPLY_HIGH_BIT = 4;
	localparam int SUPPLY_LOW_BIT = 5;
	localparam int LOAD_FAULT_BIT = 6;

	// switch vector layout: bit 2n is the high side of bridge n, bit 2n+1 its low side
	localparam int BRIDGES = 4;
	localparam int SWITCHES = 2 * BRIDGES;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// timing: clock period and filter times in ns
	localparam int CLOCK_PERIOD_NS = 8;
	localparam int OVERCURRENT_FILTER_TIME_NS = 10000;
	localparam int OPEN_LOAD_FILTER_TIME_NS = 2000000;
	// least times round up to whole cycles
	localparam int OVERCURRENT_FILTER_CYCLES =
		(OVERCURRENT_FILTER_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int OPEN_LOAD_FILTER_CYCLES =
		(OPEN_LOAD_FILTER_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

endpackage

`default_nettype wire

// ### half_bridge_fault_supervisor.sv
// What this block does
// - overcurrent held for the filter time latches the switch off and sets its bit.
// - any overcurrent or open-load detection also sets the load fault summary bit 6.
// - a switch stays off while its overcurrent bit is set; clearing re-enables it.
// - overcurrent, thermal shutdown and supply faults force outputs high impedance; stored enable bits stay unchanged.
// - open load latches its bit and summary; output drive is left unchanged.
// - overcurrent bits in second status register, open-load bits in third.
// - temperature pre-warning latches bit 1; outputs keep their state.
// - thermal shutdown latches bit 2; all outputs off until that flag is cleared.
// - supply undervoltage latches bit 5, outputs off, auto recovery when supply returns.
// - supply overvoltage latches bit 4, outputs off, auto recovery when supply returns.
// - open load set only if an active switch stays under threshold for filter time.
// - pre-warning flag clears only by software, never by the temperature falling.
`timescale 1ns/1ps
`default_nettype none

module half_bridge_fault_supervisor
	import bridge_supervisor_pkg::*;
#(
	parameter int OcFilterCycles = OVERCURRENT_FILTER_CYCLES,
	parameter int OlFilterCycles = OPEN_LOAD_FILTER_CYCLES
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic [SWITCHES-1:0] overcurrentSense,
	input wire logic [SWITCHES-1:0] openLoadSense,
	input wire logic thermalWarnSense,
	input wire logic thermalCutoffSense,
	input wire logic supplyLowSense,
	input wire logic supplyHighSense,
	output logic [BRIDGES-1:0] highSideDrive,
	output logic [BRIDGES-1:0] lowSideDrive
);

	localparam int OC_W = $clog2(OcFilterCycles + 1);
	localparam int OL_W = $clog2(OlFilterCycles + 1);

	if (OcFilterCycles < 1 || OlFilterCycles < 1) begin : bad_filter
		$error("filter cycle counts must be at least one");
	end

	function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [7:0] offset);
		hits = addr[ADDR_W-1:2] == offset[ADDR_W-1:2];
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] addr);
		mapped = hits(addr, BRIDGE_ACTIVATION_CTRL) || hits(addr, GLOBAL_STATUS_ONE) ||
			hits(addr, OVERCURRENT_STATUS_REG) || hits(addr, OPEN_LOAD_STATUS_REG);
	endfunction

	// stored enables: bit 2n high_side_drive_on_n, bit 2n+1 low_side_drive_on_n
	logic [SWITCHES-1:0] bridgeActivation;
	logic [SWITCHES-1:0] overcurrentStatus;
	logic [SWITCHES-1:0] openLoadStatus;
	logic thermalPrewarnFlag;
	logic thermalCutoffFlag;
	logic supplyLowFlag;
	logic supplyHighFlag;
	logic loadFaultSummary;
	logic [SWITCHES-1:0] gateOn;
	logic [SWITCHES-1:0] allowed;
	logic [SWITCHES-1:0] ocActive;
	logic [SWITCHES-1:0] ocFire;
	logic [SWITCHES-1:0] olActive;
	logic [SWITCHES-1:0] olFire;
	logic [OC_W-1:0] ocCount [SWITCHES];
	logic [OL_W-1:0] olCount [SWITCHES];

	// ---------------- AXI4-Lite slave ----------------
	logic awHeld;
	logic wHeld;
	logic [ADDR_W-1:0] writeAddr;
	logic [31:0] writeData;
	logic [3:0] writeStrb;
	logic doWrite;
	logic [7:0] clearMask;
	logic wrCtrl;
	logic wrGlobal;
	logic wrOc;
	logic wrOl;

	assign awready = !awHeld && !bvalid;
	assign wready = !wHeld && !bvalid;
	assign arready = !rvalid;
	assign doWrite = awHeld && wHeld && !bvalid;
	// only the low byte lane carries register bits
	assign clearMask = writeStrb[0] ? writeData[7:0] : 8'h00;
	assign wrCtrl = doWrite && hits(writeAddr, BRIDGE_ACTIVATION_CTRL) && writeStrb[0];
	assign wrGlobal = doWrite && hits(writeAddr, GLOBAL_STATUS_ONE);
	assign wrOc = doWrite && hits(writeAddr, OVERCURRENT_STATUS_REG);
	assign wrOl = doWrite && hits(writeAddr, OPEN_LOAD_STATUS_REG);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			awHeld <= 1'b0;
			writeAddr <= '0;
		end else if (awvalid && awready) begin
			awHeld <= 1'b1;
			writeAddr <= awaddr;
		end else if (doWrite) begin
			awHeld <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wHeld <= 1'b0;
			writeData <= 32'h0000_0000;
			writeStrb <= 4'h0;
		end else if (wvalid && wready) begin
			wHeld <= 1'b1;
			writeData <= wdata;
			writeStrb <= wstrb;
		end else if (doWrite) begin
			wHeld <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (doWrite) begin
			bvalid <= 1'b1;
			bresp <= mapped(writeAddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
			rdata <= 32'h0000_0000;
			if (hits(araddr, BRIDGE_ACTIVATION_CTRL)) begin
				rdata[SWITCHES-1:0] <= bridgeActivation;
			end else if (hits(araddr, GLOBAL_STATUS_ONE)) begin
				rdata[THERMAL_PREWARN_BIT] <= thermalPrewarnFlag;
				rdata[THERMAL_CUTOFF_BIT] <= thermalCutoffFlag;
				rdata[SUPPLY_HIGH_BIT] <= supplyHighFlag;
				rdata[SUPPLY_LOW_BIT] <= supplyLowFlag;
				rdata[LOAD_FAULT_BIT] <= loadFaultSummary;
			end else if (hits(araddr, OVERCURRENT_STATUS_REG)) begin
				rdata[SWITCHES-1:0] <= overcurrentStatus;
			end else if (hits(araddr, OPEN_LOAD_STATUS_REG)) begin
				rdata[SWITCHES-1:0] <= openLoadStatus;
			end
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ---------------- control register ----------------
	// faults never touch this register, only the software write does
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			bridgeActivation <= CTRL_RESET;
		end else if (wrCtrl) begin
			bridgeActivation <= writeData[SWITCHES-1:0];
		end
	end

	// ---------------- per-switch filters ----------------
	for (genvar i = 0; i < SWITCHES; i++) begin : switch_filter
		assign ocActive[i] = overcurrentSense[i] && gateOn[i] && !overcurrentStatus[i];
		assign ocFire[i] = ocActive[i] && ocCount[i] == OC_W'(OcFilterCycles - 1);
		assign olActive[i] = openLoadSense[i] && gateOn[i] && !openLoadStatus[i];
		assign olFire[i] = olActive[i] && olCount[i] == OL_W'(OlFilterCycles - 1);

		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b) begin
				ocCount[i] <= '0;
			end else if (!ocActive[i] || ocFire[i]) begin
				ocCount[i] <= '0;
			end else begin
				ocCount[i] <= ocCount[i] + 1'b1;
			end
		end

		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b) begin
				olCount[i] <= '0;
			end else if (!olActive[i] || olFire[i]) begin
				olCount[i] <= '0;
			end else begin
				olCount[i] <= olCount[i] + 1'b1;
			end
		end
	end

	// ---------------- status flags: set wins over a write-one clear ----------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			overcurrentStatus <= STATUS_RESET;
		end else begin
			overcurrentStatus <= (overcurrentStatus & ~(wrOc ? clearMask : 8'h00)) | ocFire;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			openLoadStatus <= STATUS_RESET;
		end else begin
			openLoadStatus <= (openLoadStatus & ~(wrOl ? clearMask : 8'h00)) | olFire;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			loadFaultSummary <= 1'b0;
		end else if (|(ocFire | olFire)) begin
			loadFaultSummary <= 1'b1;
		end else if (wrGlobal && clearMask[LOAD_FAULT_BIT]) begin
			loadFaultSummary <= 1'b0;
		end
	end

	// thermal and supply sensors are levels; the flags stay latched until cleared
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			thermalPrewarnFlag <= 1'b0;
		end else if (thermalWarnSense) begin
			thermalPrewarnFlag <= 1'b1;
		end else if (wrGlobal && clearMask[THERMAL_PREWARN_BIT]) begin
			thermalPrewarnFlag <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			thermalCutoffFlag <= 1'b0;
		end else if (thermalCutoffSense) begin
			thermalCutoffFlag <= 1'b1;
		end else if (wrGlobal && clearMask[THERMAL_CUTOFF_BIT]) begin
			thermalCutoffFlag <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			supplyLowFlag <= 1'b0;
		end else if (supplyLowSense) begin
			supplyLowFlag <= 1'b1;
		end else if (wrGlobal && clearMask[SUPPLY_LOW_BIT]) begin
			supplyLowFlag <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			supplyHighFlag <= 1'b0;
		end else if (supplyHighSense) begin
			supplyHighFlag <= 1'b1;
		end else if (wrGlobal && clearMask[SUPPLY_HIGH_BIT]) begin
			supplyHighFlag <= 1'b0;
		end
	end

	// ---------------- output stage ----------------
	// supply faults gate on the live sensor, not the flag, so outputs recover on their own;
	// open-load status is deliberately absent here
	assign allowed = bridgeActivation & ~overcurrentStatus &
		{SWITCHES{!thermalCutoffFlag && !supplyLowSense && !supplyHighSense}};

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			gateOn <= '0;
		end else begin
			gateOn <= allowed;
		end
	end

	for (genvar n = 0; n < BRIDGES; n++) begin : bridge_out
		assign highSideDrive[n] = gateOn[2*n];
		assign lowSideDrive[n] = gateOn[2*n+1];
	end

	// ---------------- assertions ----------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence supplyGood;
		!supplyLowSense && !supplyHighSense && !thermalCutoffFlag;
	endsequence

	sequence switch0Wanted;
		bridgeActivation[0] && !overcurrentStatus[0];
	endsequence

	for (genvar i = 0; i < SWITCHES; i++) begin : switch_check
		oc_latch_a: assert property (ocFire[i] |=> overcurrentStatus[i] ##1 !gateOn[i])
			else $error("overcurrent filter expiry did not latch the switch off");
		oc_abandon_a: assert property ($rose(overcurrentStatus[i]) |-> $past(ocFire[i]))
			else $error("overcurrent bit set without a full filter count");
		oc_hold_a: assert property (overcurrentStatus[i] |=> !gateOn[i])
			else $error("switch driven while its overcurrent bit is set");
		open_load_a: assert property ($rose(openLoadStatus[i]) |-> $past(olFire[i]) &&
			$past(gateOn[i]))
			else $error("open-load bit set without filtered low current on an active switch");
		ol_drive_a: assert property (olFire[i] && allowed[i] |=> openLoadStatus[i] && gateOn[i])
			else $error("open-load detection changed the output drive");
	end

	load_summary_a: assert property (|(ocFire | olFire) |=> loadFaultSummary)
		else $error("load fault summary not set by a switch fault");
	prewarn_keep_a: assert property (thermalPrewarnFlag && !(wrGlobal &&
		clearMask[THERMAL_PREWARN_BIT]) |=> thermalPrewarnFlag)
		else $error("pre-warning flag dropped without a clear");
	prewarn_drive_a: assert property (thermalWarnSense ##1 (supplyGood and switch0Wanted)
		|=> gateOn[0])
		else $error("pre-warning turned an output off");
	cutoff_off_a: assert property (thermalCutoffFlag |=> gateOn == '0)
		else $error("output driven during thermal cutoff");
	supply_off_a: assert property (supplyLowSense || supplyHighSense |=>
		gateOn == '0 && supplyLowFlag == $past(supplyLowSense || supplyLowFlag))
		else $error("output driven during a supply fault");
	supply_recover_a: assert property (supplyLowSense ##1 (supplyGood and switch0Wanted)
		|=> gateOn[0] && supplyLowFlag)
		else $error("output did not recover with the supply");
	ctrl_kept_a: assert property (!wrCtrl |=> $stable(bridgeActivation))
		else $error("enable bits changed without a software write");

endmodule

`default_nettype wire

// ### host_model.sv
`timescale 1ns/1ps
`default_nettype none

// host side of the register bus; every signal moves by nba just after a rising edge
module host_model
	import bridge_supervisor_pkg::*;
(
	input wire logic clock,
	output var logic awvalid,
	input wire logic awready,
	output var logic [ADDR_W-1:0] awaddr,
	output var logic wvalid,
	input wire logic wready,
	output var logic [31:0] wdata,
	input wire logic bvalid,
	output var logic bready,
	input wire logic [1:0] bresp,
	output var logic arvalid,
	input wire logic arready,
	output var logic [ADDR_W-1:0] araddr,
	input wire logic rvalid,
	output var logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
	end

	// address and data offered together, each dropped when taken
	// handshakes are judged mid-cycle, where the slave's flops have settled, and acted on
	// at the following rising edge, the one at which the slave sees them
	task automatic busWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
			output bit ok);
		bit awTaken;
		bit wTaken;
		ok = 0;
		@(posedge clock);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		for (int n = 0; n < 50 && !ok; n++) begin
			@(negedge clock);
			awTaken = awvalid && awready;
			wTaken = wvalid && wready;
			ok = bvalid && bready;
			if (ok)
				r = bresp;
			@(posedge clock);
			if (awTaken)
				awvalid <= 1'b0;
			if (wTaken)
				wvalid <= 1'b0;
			if (ok)
				bready <= 1'b0;
		end
	endtask

	task automatic busRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
			output bit ok);
		bit arTaken;
		ok = 0;
		@(posedge clock);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		for (int n = 0; n < 50 && !ok; n++) begin
			@(negedge clock);
			arTaken = arvalid && arready;
			ok = rvalid && rready;
			if (ok) begin
				d = rdata;
				r = rresp;
			end
			@(posedge clock);
			if (arTaken)
				arvalid <= 1'b0;
			if (ok)
				rready <= 1'b0;
		end
	endtask
endmodule

`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
	$display("unexpected at %0t: got %h exp %h", $time, got, exp); end end

module tb_top
	import bridge_supervisor_pkg::*;
;
	localparam int OC = 4;
	localparam int OL = 6;
	logic clock, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic [7:0] overcurrentSense, openLoadSense;
	logic thermalWarnSense, thermalCutoffSense, supplyLowSense, supplyHighSense;
	logic [3:0] highSideDrive, lowSideDrive;
	int err_total = 0;
	int check_count = 0;

	half_bridge_fault_supervisor #(.OcFilterCycles(OC), .OlFilterCycles(OL)) i_half_bridge_fault_supervisor (
		.clock(clock), .rst_b(rst_b), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
		.rresp(rresp), .overcurrentSense(overcurrentSense), .openLoadSense(openLoadSense),
		.thermalWarnSense(thermalWarnSense), .thermalCutoffSense(thermalCutoffSense),
		.supplyLowSense(supplyLowSense), .supplyHighSense(supplyHighSense),
		.highSideDrive(highSideDrive), .lowSideDrive(lowSideDrive));

	host_model host (.clock(clock), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp));

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		logic [1:0] r;
		bit ok;
		host.busWrite(a, d, r, ok);
		if (!ok) begin
			err_total++;
			finish_test();
		end else
			`CHK(r, er)
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
		logic [31:0] d;
		logic [1:0] r;
		bit ok;
		host.busRead(a, d, r, ok);
		if (!ok) begin
			err_total++;
			finish_test();
		end else begin
			`CHK(d, e)
			`CHK(r, er)
		end
	endtask

	// let the edge's updates land before looking at the drives
	task automatic settle();
		@(posedge clock);
		#1;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask

	initial begin
		int b;
		rst_b = 1'b0;
		{overcurrentSense, openLoadSense} = 16'h0000;
		{thermalWarnSense, thermalCutoffSense, supplyLowSense, supplyHighSense} = 4'h0;
		cyc(3);
		rst_b <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rdChk(8'(4 * i), 32'h0000_0000);
		end
		rdChk(8'h10, 32'h0000_0000, RESP_SLVERR);
		wr(8'h10, 32'h0000_00FF, RESP_SLVERR);
		wr(BRIDGE_ACTIVATION_CTRL, 32'h0000_0009);
		settle();
		`CHK({highSideDrive, lowSideDrive}, 8'h12)
		// overcurrent one cycle short of the filter
		@(posedge clock) overcurrentSense <= 8'h01;
		cyc(OC - 1);
		overcurrentSense <= 8'h00;
		cyc(3);
		rdChk(OVERCURRENT_STATUS_REG, 32'h0000_0000);
		`CHK(highSideDrive, 4'h1)
		@(posedge clock) overcurrentSense <= 8'h01;
		cyc(OC + 3);
		overcurrentSense <= 8'h00;
		settle();
		`CHK(highSideDrive, 4'h0)
		rdChk(OVERCURRENT_STATUS_REG, 32'h0000_0001);
		rdChk(GLOBAL_STATUS_ONE, 32'h1 << LOAD_FAULT_BIT);
		rdChk(BRIDGE_ACTIVATION_CTRL, 32'h0000_0009);
		`CHK(highSideDrive, 4'h0)
		wr(OVERCURRENT_STATUS_REG, 32'h0000_0001);
		wr(GLOBAL_STATUS_ONE, 32'h1 << LOAD_FAULT_BIT);
		settle();
		`CHK(highSideDrive, 4'h1)
		// bit 1 belongs to an undriven switch and must stay clear
		@(posedge clock) openLoadSense <= 8'h0A;
		cyc(OL + 3);
		openLoadSense <= 8'h00;
		settle();
		`CHK({highSideDrive, lowSideDrive}, 8'h12)
		rdChk(OPEN_LOAD_STATUS_REG, 32'h0000_0008);
		rdChk(GLOBAL_STATUS_ONE, 32'h1 << LOAD_FAULT_BIT);
		wr(OPEN_LOAD_STATUS_REG, 32'h0000_0008);
		wr(GLOBAL_STATUS_ONE, 32'h1 << LOAD_FAULT_BIT);
		rdChk(OPEN_LOAD_STATUS_REG, 32'h0000_0000);
		@(posedge clock) thermalWarnSense <= 1'b1;
		cyc(2);
		thermalWarnSense <= 1'b0;
		cyc(2);
		rdChk(GLOBAL_STATUS_ONE, 32'h1 << THERMAL_PREWARN_BIT);
		`CHK({highSideDrive, lowSideDrive}, 8'h12)
		wr(GLOBAL_STATUS_ONE, 32'h1 << THERMAL_PREWARN_BIT);
		rdChk(GLOBAL_STATUS_ONE, 32'h0000_0000);
		@(posedge clock) thermalCutoffSense <= 1'b1;
		cyc(2);
		thermalCutoffSense <= 1'b0;
		cyc(3);
		settle();
		`CHK({highSideDrive, lowSideDrive}, 8'h00)
		rdChk(GLOBAL_STATUS_ONE, 32'h1 << THERMAL_CUTOFF_BIT);
		rdChk(BRIDGE_ACTIVATION_CTRL, 32'h0000_0009);
		wr(GLOBAL_STATUS_ONE, 32'h1 << THERMAL_CUTOFF_BIT);
		settle();
		`CHK({highSideDrive, lowSideDrive}, 8'h12)
		for (int i = 0; i < 2; i++) begin
			b = (i == 0) ? SUPPLY_LOW_BIT : SUPPLY_HIGH_BIT;
			@(posedge clock) supplyLowSense <= (i == 0);
			supplyHighSense <= (i == 1);
			cyc(3);
			settle();
			`CHK({highSideDrive, lowSideDrive}, 8'h00)
			rdChk(GLOBAL_STATUS_ONE, 32'h1 << b);
			@(posedge clock) {supplyLowSense, supplyHighSense} <= 2'h0;
			cyc(2);
			settle();
			`CHK({highSideDrive, lowSideDrive}, 8'h12)
			rdChk(GLOBAL_STATUS_ONE, 32'h1 << b);
			wr(GLOBAL_STATUS_ONE, 32'h1 << b);
		end
		rdChk(GLOBAL_STATUS_ONE, 32'h0000_0000);
		finish_test();
	end
endmodule

`default_nettype wire
